/* File: core/hdx_slave_defines.svh */
// constants of the half-duplex polled slave link: offsets, fields, resets, timing
// assumes a 100 MHz system clock and an APB slave with 32-bit data
//
// Operation
// - bit rate selects 300 to 38400 baud, 9600 after reset.
// - station address 0 to 254, default 1; packets to it are accepted.
// - only modem mode drives request-to-send and waits for clear-to-send.
// - duplicate detection, on by default, discards a repeated received packet.
// - check is CRC or BCC, CRC by default; both stations must agree.
// - request-to-send held 0 to 255 times 5 ms after the last character.
// - after raising request-to-send wait 0 to 255 times 5 ms before sampling clear-to-send.
// - queued message waits for poll up to 0..65535 times 20 ms, then errors.
// - poll timeout of zero disables the poll wait timer.
// - pre-send delay of 0 to 255 times 5 ms before every transmission.
// - message without acknowledge is resent up to 0..255 times, default 3.
// - with silence enabled and nothing queued, a poll gets no reply.
// - slave transmits only in answer to a poll addressed to it, or to resend a message after a NAK or ack timeout.
// - address 255 is broadcast: accepted, never originated nor answered.
`ifndef HDX_SLAVE_DEFINES_SVH
`define HDX_SLAVE_DEFINES_SVH

`define OFS_CTRL 12'h000
`define OFS_ADDR 12'h004
`define OFS_DELAY 12'h008
`define OFS_POLL 12'h00C
`define OFS_STATUS 12'h010

`define CTRL_BAUD_LSB 0
`define CTRL_MODEM_BIT 3
`define CTRL_DUP_BIT 4
`define CTRL_CRC_BIT 5
`define CTRL_SILENCE_BIT 6
`define CTRL_QUEUE_BIT 8

`define DELAY_OFF_LSB 0
`define DELAY_SEND_LSB 8
`define DELAY_PRE_LSB 16
`define DELAY_RETRY_LSB 24

`define RST_BAUD 3'h5
`define RST_MODEM 1'b0
`define RST_DUP 1'b1
`define RST_CRC 1'b1
`define RST_SILENCE 1'b0
`define RST_ADDR 8'h01
`define RST_OFF 8'h00
`define RST_SEND 8'h00
`define RST_PRE 8'h00
`define RST_RETRY 8'h03
`define RST_POLL 16'h0BB8

`define BROADCAST_ADDR 8'hFF
`define CLK_HZ 100000000
`define CLK_NS 10
`define TICK_NS 5000000
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`define TICKS_PER_POLL_UNIT 2'h3
`define ACK_WAIT_TICKS 8'hC8

`endif

/* File: core/hdx_slave_pkg.sv */
// types of the half-duplex polled slave link
// assumes the character layer delivers decoded packets as one-cycle events
package hdx_slave_pkg;
	typedef enum logic [1:0] {PKT_POLL, PKT_ACK, PKT_NAK, PKT_DATA} pkt_kind_t;
	typedef enum logic {TX_EMPTY, TX_MESSAGE} tx_kind_t;
	typedef struct packed {
		logic [7:0] dest;
		logic [7:0] seq;
		pkt_kind_t kind;
		logic check_ok;
	} rx_pkt_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_PRESEND, ST_RTS_WAIT, ST_CTS_WAIT, ST_SEND, ST_RTS_HOLD, ST_ACK_WAIT
	} tx_state_t;
endpackage

/* File: core/hdx_timebase.sv */
// timebase of the slave link: bit rate enable, 5 ms and 20 ms enables
// assumes one clock; every output is a one-cycle enable
`timescale 1ns/1ns
`include "hdx_slave_defines.svh"
module hdx_timebase #(
	parameter int CLK_HZ = `CLK_HZ,
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [2:0] baud_sel_i,
	output logic baud_tick_o,
	output logic tick5_o,
	output logic tick20_o
);
	logic [31:0] baud_cnt;
	logic [31:0] baud_div;
	logic [31:0] tick_cnt;
	logic [1:0] quarter;

	// 300 doubled per step, except the top step which is 38400
	always_comb begin
		baud_div = 32'(CLK_HZ / (300 << baud_sel_i)) - 32'h1;
		if (baud_sel_i == 3'h7) begin
			baud_div = 32'(CLK_HZ / 38400) - 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || baud_cnt >= baud_div) begin
			baud_cnt <= 32'h0;
		end else begin
			baud_cnt <= baud_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			baud_tick_o <= 1'b0;
		end else begin
			baud_tick_o <= (baud_cnt >= baud_div);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || tick_cnt == 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= 32'h0;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tick5_o <= 1'b0;
			tick20_o <= 1'b0;
			quarter <= 2'h0;
		end else begin
			tick5_o <= (tick_cnt == 32'(TICK_CYCLES - 1));
			tick20_o <= (tick_cnt == 32'(TICK_CYCLES - 1)) && (quarter == `TICKS_PER_POLL_UNIT);
			if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
				quarter <= quarter + 2'h1;
			end
		end
	end
endmodule // hdx_timebase

/* File: core/hdx_slave_link.sv */
// slave side of a polled multi-drop half-duplex packet link with APB registers
// assumes a character layer that decodes received packets into rx events and
// sends the selected reply when tx_req_o is high, pulsing tx_done_i after its last character
`timescale 1ns/1ns
`include "hdx_slave_defines.svh"
module hdx_slave_link #(
	parameter int CLK_HZ = `CLK_HZ,
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic rx_valid_i,
	input wire hdx_slave_pkg::rx_pkt_t rx_pkt_i,
	output logic deliver_o,
	output logic [7:0] deliver_seq_o,
	output logic tx_req_o,
	output hdx_slave_pkg::tx_kind_t tx_kind_o,
	input wire logic tx_done_i,
	output logic check_crc_o,
	output logic baud_tick_o,
	output logic rts_o,
	input wire logic cts_i
);
	logic [2:0] baud_sel;
	logic modem_en;
	logic dup_en;
	logic crc_sel;
	logic silence_en;
	logic [7:0] node_addr;
	logic [7:0] rts_off_dly;
	logic [7:0] rts_send_dly;
	logic [7:0] presend_dly;
	logic [7:0] retry_max;
	logic [15:0] poll_timeout;
	logic peer_message_request;
	logic msg_err;
	logic msg_done;
	logic [7:0] last_seq;
	logic last_seq_valid;
	logic [2:0] cts_sync;
	logic cts_level;
	logic tick5;
	logic tick20;
	logic [7:0] dly_cnt;
	logic [7:0] retry_cnt;
	logic [15:0] poll_cnt;
	hdx_slave_pkg::tx_state_t state;
	hdx_slave_pkg::tx_state_t next_state;
	logic setup_phase;
	logic wr_access;
	logic mapped;
	logic for_me;
	logic for_me_only;
	logic is_poll;
	logic is_ack;
	logic is_nak;
	logic is_data;
	logic is_dup;
	logic dly_zero;
	logic poll_expire;
	logic ack_timeout;
	logic send_done;
	logic give_up;
	logic queue_wr;

	hdx_timebase #(
		.CLK_HZ(CLK_HZ),
		.TICK_CYCLES(TICK_CYCLES)
	) u_timebase (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.baud_sel_i(baud_sel),
		.baud_tick_o(baud_tick_o),
		.tick5_o(tick5),
		.tick20_o(tick20)
	);

	// apb: read data captured in setup, answered with no wait state
	assign setup_phase = psel_i && !penable_i;
	assign wr_access = psel_i && penable_i && pwrite_i;
	assign pready_o = 1'b1;
	always_comb begin
		unique case (paddr_i)
			`OFS_CTRL, `OFS_ADDR, `OFS_DELAY, `OFS_POLL, `OFS_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign queue_wr = wr_access && paddr_i == `OFS_CTRL && pwdata_i[`CTRL_QUEUE_BIT];

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			baud_sel <= `RST_BAUD;
			modem_en <= `RST_MODEM;
			dup_en <= `RST_DUP;
			crc_sel <= `RST_CRC;
			silence_en <= `RST_SILENCE;
			node_addr <= `RST_ADDR;
			rts_off_dly <= `RST_OFF;
			rts_send_dly <= `RST_SEND;
			presend_dly <= `RST_PRE;
			retry_max <= `RST_RETRY;
			poll_timeout <= `RST_POLL;
		end else if (wr_access) begin
			unique case (paddr_i)
				`OFS_CTRL: begin
					baud_sel <= pwdata_i[`CTRL_BAUD_LSB +: 3];
					modem_en <= pwdata_i[`CTRL_MODEM_BIT];
					dup_en <= pwdata_i[`CTRL_DUP_BIT];
					crc_sel <= pwdata_i[`CTRL_CRC_BIT];
					silence_en <= pwdata_i[`CTRL_SILENCE_BIT];
				end
				`OFS_ADDR: begin
					// 255 is reserved for broadcast and cannot be our own address
					if (pwdata_i[7:0] != `BROADCAST_ADDR) begin
						node_addr <= pwdata_i[7:0];
					end
				end
				`OFS_DELAY: begin
					rts_off_dly <= pwdata_i[`DELAY_OFF_LSB +: 8];
					rts_send_dly <= pwdata_i[`DELAY_SEND_LSB +: 8];
					presend_dly <= pwdata_i[`DELAY_PRE_LSB +: 8];
					retry_max <= pwdata_i[`DELAY_RETRY_LSB +: 8];
				end
				`OFS_POLL: poll_timeout <= pwdata_i[15:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h0;
		end else if (setup_phase) begin
			unique case (paddr_i)
				`OFS_CTRL: prdata_o <= {23'h0, peer_message_request, 1'b0, silence_en, crc_sel,
					dup_en, modem_en, baud_sel};
				`OFS_ADDR: prdata_o <= {24'h0, node_addr};
				`OFS_DELAY: prdata_o <= {retry_max, presend_dly, rts_send_dly, rts_off_dly};
				`OFS_POLL: prdata_o <= {16'h0, poll_timeout};
				`OFS_STATUS: prdata_o <= {16'h0, retry_cnt, 1'b0, 4'(state), cts_level,
					msg_done, msg_err};
				default: prdata_o <= 32'h0;
			endcase
		end
	end

	assign check_crc_o = crc_sel;

	// clear-to-send pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cts_sync <= 3'h0;
			cts_level <= 1'b0;
		end else begin
			cts_sync <= {cts_sync[1:0], cts_i};
			if (cts_sync[2] == cts_sync[1]) begin
				cts_level <= cts_sync[2];
			end
		end
	end

	// receive filter
	assign is_poll = rx_pkt_i.kind == hdx_slave_pkg::PKT_POLL;
	assign is_ack = rx_pkt_i.kind == hdx_slave_pkg::PKT_ACK;
	assign is_nak = rx_pkt_i.kind == hdx_slave_pkg::PKT_NAK;
	assign is_data = rx_pkt_i.kind == hdx_slave_pkg::PKT_DATA;
	assign for_me_only = rx_valid_i && rx_pkt_i.check_ok && rx_pkt_i.dest == node_addr;
	assign for_me = for_me_only || (rx_valid_i && rx_pkt_i.check_ok
		&& rx_pkt_i.dest == `BROADCAST_ADDR);
	assign is_dup = dup_en && last_seq_valid && rx_pkt_i.seq == last_seq;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			last_seq <= 8'h0;
			last_seq_valid <= 1'b0;
		end else if (for_me && is_data && !is_dup) begin
			last_seq <= rx_pkt_i.seq;
			last_seq_valid <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			deliver_o <= 1'b0;
			deliver_seq_o <= 8'h0;
		end else begin
			deliver_o <= for_me && is_data && !is_dup;
			if (for_me && is_data && !is_dup) begin
				deliver_seq_o <= rx_pkt_i.seq;
			end
		end
	end

	// transmit sequencing
	assign dly_zero = dly_cnt == 8'h0;
	assign send_done = state == hdx_slave_pkg::ST_SEND && tx_done_i;
	assign ack_timeout = state == hdx_slave_pkg::ST_ACK_WAIT && dly_zero;
	assign give_up = (ack_timeout || (state == hdx_slave_pkg::ST_ACK_WAIT && for_me_only && is_nak))
		&& retry_cnt == retry_max;
	assign poll_expire = peer_message_request && state == hdx_slave_pkg::ST_IDLE
		&& poll_timeout != 16'h0 && poll_cnt == 16'h0;

	always_comb begin
		next_state = state;
		unique case (state)
			hdx_slave_pkg::ST_IDLE: begin
				// a broadcast poll never gets an answer
				if (for_me_only && is_poll && (peer_message_request || !silence_en)) begin
					next_state = hdx_slave_pkg::ST_PRESEND;
				end
			end
			hdx_slave_pkg::ST_PRESEND: begin
				if (dly_zero) begin
					next_state = modem_en ? hdx_slave_pkg::ST_RTS_WAIT
						: hdx_slave_pkg::ST_SEND;
				end
			end
			hdx_slave_pkg::ST_RTS_WAIT: begin
				if (dly_zero) begin
					next_state = hdx_slave_pkg::ST_CTS_WAIT;
				end
			end
			hdx_slave_pkg::ST_CTS_WAIT: begin
				if (cts_level) begin
					next_state = hdx_slave_pkg::ST_SEND;
				end
			end
			hdx_slave_pkg::ST_SEND: begin
				if (tx_done_i) begin
					next_state = modem_en ? hdx_slave_pkg::ST_RTS_HOLD
						: (tx_kind_o == hdx_slave_pkg::TX_MESSAGE ? hdx_slave_pkg::ST_ACK_WAIT
						: hdx_slave_pkg::ST_IDLE);
				end
			end
			hdx_slave_pkg::ST_RTS_HOLD: begin
				if (dly_zero) begin
					next_state = tx_kind_o == hdx_slave_pkg::TX_MESSAGE
						? hdx_slave_pkg::ST_ACK_WAIT : hdx_slave_pkg::ST_IDLE;
				end
			end
			hdx_slave_pkg::ST_ACK_WAIT: begin
				if (for_me_only && is_ack) begin
					next_state = hdx_slave_pkg::ST_IDLE;
				end else if (give_up) begin
					next_state = hdx_slave_pkg::ST_IDLE;
				end else if (ack_timeout || (for_me_only && is_nak)) begin
					next_state = hdx_slave_pkg::ST_PRESEND;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= hdx_slave_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// one delay counter, loaded on entry to each timed state, counts 5 ms ticks
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			dly_cnt <= 8'h0;
		end else if (next_state != state || (state == hdx_slave_pkg::ST_ACK_WAIT
			&& next_state == hdx_slave_pkg::ST_PRESEND)) begin
			unique case (next_state)
				hdx_slave_pkg::ST_PRESEND: dly_cnt <= presend_dly;
				hdx_slave_pkg::ST_RTS_WAIT: dly_cnt <= rts_send_dly;
				hdx_slave_pkg::ST_RTS_HOLD: dly_cnt <= rts_off_dly;
				hdx_slave_pkg::ST_ACK_WAIT: dly_cnt <= `ACK_WAIT_TICKS;
				default: dly_cnt <= 8'h0;
			endcase
		end else if (tick5 && !dly_zero) begin
			dly_cnt <= dly_cnt - 8'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_kind_o <= hdx_slave_pkg::TX_EMPTY;
		end else if (state == hdx_slave_pkg::ST_IDLE && next_state == hdx_slave_pkg::ST_PRESEND) begin
			tx_kind_o <= peer_message_request ? hdx_slave_pkg::TX_MESSAGE
				: hdx_slave_pkg::TX_EMPTY;
		end
	end

	assign tx_req_o = state == hdx_slave_pkg::ST_SEND;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rts_o <= 1'b0;
		end else begin
			rts_o <= modem_en && (next_state == hdx_slave_pkg::ST_RTS_WAIT
				|| next_state == hdx_slave_pkg::ST_CTS_WAIT || next_state == hdx_slave_pkg::ST_SEND
				|| next_state == hdx_slave_pkg::ST_RTS_HOLD);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			retry_cnt <= 8'h0;
		end else if (state == hdx_slave_pkg::ST_IDLE) begin
			retry_cnt <= 8'h0;
		end else if (state == hdx_slave_pkg::ST_ACK_WAIT && next_state == hdx_slave_pkg::ST_PRESEND) begin
			retry_cnt <= retry_cnt + 8'h1;
		end
	end

	// poll wait timer runs while a message waits idle for its poll
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !peer_message_request || state != hdx_slave_pkg::ST_IDLE) begin
			poll_cnt <= poll_timeout;
		end else if (tick20 && poll_cnt != 16'h0) begin
			poll_cnt <= poll_cnt - 16'h1;
		end
	end

	// message flags: a new request in the cycle of completion is kept
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			peer_message_request <= 1'b0;
		end else if (queue_wr) begin
			peer_message_request <= 1'b1;
		end else if (poll_expire || give_up || (state == hdx_slave_pkg::ST_ACK_WAIT
			&& for_me_only && is_ack)) begin
			peer_message_request <= 1'b0;
		end
	end

	// error and done are sticky; write one to clear, a new event wins
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			msg_err <= 1'b0;
			msg_done <= 1'b0;
		end else begin
			if (poll_expire || give_up) begin
				msg_err <= 1'b1;
			end else if (wr_access && paddr_i == `OFS_STATUS && pwdata_i[0]) begin
				msg_err <= 1'b0;
			end
			if (state == hdx_slave_pkg::ST_ACK_WAIT && for_me_only && is_ack) begin
				msg_done <= 1'b1;
			end else if (wr_access && paddr_i == `OFS_STATUS && pwdata_i[1]) begin
				msg_done <= 1'b0;
			end
		end
	end
endmodule // hdx_slave_link

/* File: tb/hdx_slave_link_assertions.sv */
// port checker of the slave link
// assumes the bind below; mirrors the modem and duplicate bits from control writes
`timescale 1ns/1ns
module hdx_slave_link_assertions (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic rx_valid_i,
	input wire hdx_slave_pkg::rx_pkt_t rx_pkt_i,
	input wire logic deliver_o,
	input wire logic [7:0] deliver_seq_o,
	input wire logic tx_req_o,
	input wire logic tx_done_i,
	input wire logic check_crc_o,
	input wire logic baud_tick_o,
	input wire logic rts_o
);
	logic wr_ctrl;
	logic modem;
	logic dup_en;
	logic seen;
	assign wr_ctrl = psel_i && penable_i && pwrite_i && paddr_i == 12'h000;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			modem <= 1'b0;
			dup_en <= 1'b1;
		end else if (wr_ctrl) begin
			modem <= pwdata_i[3];
			dup_en <= pwdata_i[4];
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			seen <= 1'b0;
		end else if (deliver_o) begin
			seen <= 1'b1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence ctrl_wr;
		wr_ctrl;
	endsequence
	sequence good_data;
		rx_valid_i && rx_pkt_i.check_ok && rx_pkt_i.kind == hdx_slave_pkg::PKT_DATA;
	endsequence
	deliver_cause_a: assert property (deliver_o |-> $past(rx_valid_i
		&& rx_pkt_i.check_ok && rx_pkt_i.kind == hdx_slave_pkg::PKT_DATA))
		else $error("deliver without a good data packet");
	deliver_seq_a: assert property (deliver_o |-> deliver_seq_o == $past(rx_pkt_i.seq))
		else $error("delivered seq differs from received");
	bad_check_a: assert property (rx_valid_i && !rx_pkt_i.check_ok |=> !deliver_o)
		else $error("packet with failed check delivered");
	dup_drop_a: assert property (good_data ##0 (dup_en && seen
		&& rx_pkt_i.seq == deliver_seq_o) |=> !deliver_o)
		else $error("duplicate packet delivered");
	crc_select_a: assert property (ctrl_wr |=> check_crc_o == $past(pwdata_i[5]))
		else $error("check method does not follow control");
	plain_no_rts_a: assert property (!modem |-> !rts_o)
		else $error("rts raised without modem mode");
	modem_rts_a: assert property (modem && tx_req_o |-> rts_o)
		else $error("modem send without rts");
	req_release_a: assert property (tx_req_o && tx_done_i |=> !tx_req_o)
		else $error("send request outlives its done");
	baud_pulse_a: assert property (baud_tick_o |=> !baud_tick_o [*8])
		else $error("bit rate pulses too close");
endmodule // hdx_slave_link_assertions
bind hdx_slave_link hdx_slave_link_assertions chk_u (.clk_i, .sys_rst_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .rx_valid_i, .rx_pkt_i, .deliver_o, .deliver_seq_o,
	.tx_req_o, .tx_done_i, .check_crc_o, .baud_tick_o, .rts_o);

/* File: tb/hdx_master_model.sv */
// polling master for the slave link: sends decoded packets, ends replies, answers rts
// assumes the slave's character layer ports; the idle rx bus shows the inverted packet
`timescale 1ns/1ns
module hdx_master_model (
	input wire logic clk_i,
	input wire logic tx_req_i,
	input wire hdx_slave_pkg::tx_kind_t tx_kind_i,
	input wire logic rts_i,
	output logic rx_valid_o,
	output hdx_slave_pkg::rx_pkt_t rx_pkt_o,
	output logic tx_done_o,
	output logic cts_o
);
	int done_lat = 3;
	int cts_lat = 2;
	int sent_all = 0;
	int sent_msg = 0;
	int cnt = 0;
	int rts_cnt = 0;
	initial begin
		rx_valid_o = 1'b0;
		rx_pkt_o = '0;
		tx_done_o = 1'b0;
		cts_o = 1'b0;
	end
	task send(input logic [7:0] d, input logic [7:0] s, input hdx_slave_pkg::pkt_kind_t k,
		input logic ok);
		rx_valid_o <= 1'b1;
		rx_pkt_o <= '{d, s, k, ok};
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_pkt_o <= hdx_slave_pkg::rx_pkt_t'(~rx_pkt_o);
		@(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (tx_req_i === 1'b1 && tx_done_o !== 1'b1) cnt++;
		else cnt = 0;
		tx_done_o <= 1'b0;
		if (cnt == done_lat) begin
			tx_done_o <= 1'b1;
			cnt = 0;
			sent_all++;
			if (tx_kind_i === hdx_slave_pkg::TX_MESSAGE) sent_msg++;
		end
		rts_cnt = rts_i ? rts_cnt + 1 : 0;
		cts_o <= rts_i && rts_cnt >= cts_lat;
	end
endmodule // hdx_master_model

/* File: tb/tb_hdx_slave_link.sv */
// self-checking bench of the slave link
// assumes the master model on the link side and an APB master task here
`timescale 1ns/1ns
module tb_hdx_slave_link;
	logic clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, serr;
	logic rx_valid_i, deliver_o, tx_req_o, tx_done_i, check_crc_o, baud_tick_o, rts_o, cts_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rdat;
	logic [7:0] deliver_seq_o;
	hdx_slave_pkg::rx_pkt_t rx_pkt_i;
	hdx_slave_pkg::tx_kind_t tx_kind_o;
	int miscompares = 0, samples_checked = 0, ndel = 0, n, m0, p;
	hdx_slave_link #(.TICK_CYCLES(10)) dut_u (.clk_i, .sys_rst_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_valid_i,
		.rx_pkt_i, .deliver_o, .deliver_seq_o, .tx_req_o, .tx_kind_o, .tx_done_i,
		.check_crc_o, .baud_tick_o, .rts_o, .cts_i);
	hdx_master_model master_u (.clk_i, .tx_req_i(tx_req_o), .tx_kind_i(tx_kind_o),
		.rts_i(rts_o), .rx_valid_o(rx_valid_i), .rx_pkt_o(rx_pkt_i), .tx_done_o(tx_done_i),
		.cts_o(cts_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (deliver_o === 1'b1) ndel++;
	task summarize;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task limit(input int c, input int lim);
		if (c >= lim) begin
			$display("[ERR] wait expected done seen timeout");
			miscompares++;
			summarize();
		end
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int c;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
		end while (pready_o !== 1'b1 && c < 20);
		limit(c, 20);
		rdat = prdata_o;
		serr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		// one idle edge: the next call never reassigns psel in this time step
		@(posedge clk_i);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	task wreq(input int lim);
		n = 0;
		while (tx_req_o !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		limit(n, lim);
	endtask
	task tick;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (baud_tick_o !== 1'b1 && n < 6000);
		limit(n, 6000);
	endtask
	task t_regs;
		rd(12'h000);
		chk("ctrl", 32'h35, rdat);
		rd(12'h004);
		chk("addr", 32'h1, rdat);
		rd(12'h008);
		chk("delay", 32'h03000000, rdat);
		rd(12'h00C);
		chk("poll", 32'h0BB8, rdat);
		rd(12'h020);
		chk("unmapped", 32'h1, serr);
		wr(12'h004, 32'hFF);
		rd(12'h004);
		chk("bcast addr", 32'h1, rdat);
		wr(12'h000, 32'h15);
		chk("bcc", 32'h0, check_crc_o);
		wr(12'h000, 32'h35);
		$display("test regs done");
	endtask
	task t_poll;
		m0 = master_u.sent_all;
		wr(12'h008, 32'h03020000);
		master_u.send(8'h01, 8'h00, hdx_slave_pkg::PKT_POLL, 1'b1);
		wreq(60);
		chk("presend", 32'h1, n >= 10 && n <= 23);
		chk("kind", hdx_slave_pkg::TX_EMPTY, tx_kind_o);
		// back to idle first, so the next two polls are judged on their address alone
		repeat (6) @(posedge clk_i);
		master_u.send(8'h02, 8'h00, hdx_slave_pkg::PKT_POLL, 1'b1);
		master_u.send(8'hFF, 8'h00, hdx_slave_pkg::PKT_POLL, 1'b1);
		wr(12'h000, 32'h75);
		master_u.send(8'h01, 8'h00, hdx_slave_pkg::PKT_POLL, 1'b1);
		repeat (40) @(posedge clk_i);
		chk("replies", m0 + 1, master_u.sent_all);
		wr(12'h000, 32'h35);
		wr(12'h008, 32'h03000000);
		$display("test poll done");
	endtask
	task t_data;
		m0 = ndel;
		master_u.send(8'h01, 8'h05, hdx_slave_pkg::PKT_DATA, 1'b1);
		master_u.send(8'h01, 8'h05, hdx_slave_pkg::PKT_DATA, 1'b1);
		master_u.send(8'h03, 8'h09, hdx_slave_pkg::PKT_DATA, 1'b1);
		master_u.send(8'h01, 8'h07, hdx_slave_pkg::PKT_DATA, 1'b0);
		master_u.send(8'hFF, 8'h06, hdx_slave_pkg::PKT_DATA, 1'b1);
		wr(12'h000, 32'h25);
		master_u.send(8'hFF, 8'h06, hdx_slave_pkg::PKT_DATA, 1'b1);
		repeat (3) @(posedge clk_i);
		chk("delivered", m0 + 3, ndel);
		chk("seq", 32'h6, deliver_seq_o);
		wr(12'h000, 32'h35);
		$display("test data done");
	endtask
	task t_msg;
		m0 = master_u.sent_msg;
		wr(12'h000, 32'h135);
		master_u.send(8'h01, 8'h00, hdx_slave_pkg::PKT_POLL, 1'b1);
		wreq(60);
		repeat (6) @(posedge clk_i);
		master_u.send(8'h01, 8'h00, hdx_slave_pkg::PKT_ACK, 1'b1);
		rd(12'h010);
		chk("msg done", 32'h1, rdat[1]);
		wr(12'h010, 32'h3);
		wr(12'h008, 32'h01000000);
		wr(12'h000, 32'h135);
		master_u.send(8'h01, 8'h00, hdx_slave_pkg::PKT_POLL, 1'b1);
		repeat (2) begin
			wreq(60);
			repeat (6) @(posedge clk_i);
			master_u.send(8'h01, 8'h00, hdx_slave_pkg::PKT_NAK, 1'b1);
		end
		repeat (5) @(posedge clk_i);
		chk("sends", m0 + 3, master_u.sent_msg);
		rd(12'h010);
		chk("msg err", 32'h1, rdat[0]);
		wr(12'h010, 32'h3);
		wr(12'h00C, 32'h1);
		wr(12'h000, 32'h135);
		repeat (80) @(posedge clk_i);
		rd(12'h010);
		chk("poll timeout", 32'h1, rdat[0]);
		wr(12'h010, 32'h3);
		wr(12'h00C, 32'h0);
		wr(12'h000, 32'h135);
		repeat (80) @(posedge clk_i);
		rd(12'h010);
		chk("no timeout", 32'h0, rdat[0]);
		$display("test message done");
	endtask
	task t_modem;
		master_u.cts_lat = 30;
		wr(12'h000, 32'h3D);
		wr(12'h008, 32'h01000203);
		wr(12'h00C, 32'h0BB8);
		master_u.send(8'h01, 8'h00, hdx_slave_pkg::PKT_POLL, 1'b1);
		wreq(200);
		chk("cts wait", 32'h1, n >= 30);
		repeat (5) @(posedge clk_i);
		chk("rts hold", 32'h1, rts_o);
		repeat (40) @(posedge clk_i);
		chk("rts off", 32'h0, rts_o);
		$display("test modem done");
	endtask
	task t_baud;
		for (int c = 6; c < 8; c++) begin
			p = 100000000 / (c == 6 ? 19200 : 38400);
			wr(12'h000, 32'h30 | c);
			tick();
			tick();
			chk("baud", 32'h1, n >= p - 2 && n <= p + 2);
		end
		$display("test baud done");
	endtask
	initial begin
		sys_rst_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_poll();
		t_data();
		t_msg();
		t_modem();
		t_baud();
		summarize();
	end
endmodule // tb_hdx_slave_link
